/* File: src/spp_packetizer.sv */
`timescale 1ns/100ps
module spp_packetizer #(
    parameter int PIX_W = spp_pkg::PIX_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic use_10bit,
    input wire logic stereo,
    input wire logic [1:0] col_bin,
    input wire logic [PIX_W-1:0] pix,
    input wire logic [PIX_W-1:0] slave_pix,
    input wire logic row_active,
    input wire logic image_active,
    output logic pix_take,
    output logic pkt_start,
    output logic ser_out
);
    // ==========================================================
    // state
    typedef struct packed {
        logic q_row;
        logic q_img;
        logic [PIX_W-1:0] p_pix;
        logic [PIX_W-1:0] p_spix;
        logic p_row;
        logic p_img;
        logic [PIX_W-1:0] n_pix;
        logic [PIX_W-1:0] n_spix;
        logic n_row;
        logic n_img;
        logic st;
        logic w10;
        logic [1:0] bin;
        logic [1:0] rep;
        logic take;
        logic start;
        logic pkt18;
    } spp_state_s;

    spp_state_s cur;
    spp_state_s next_cur;
    logic [spp_pkg::SHIFT_W-1:0] word;
    logic [4:0] len;
    logic last;
    logic almost;
    logic code_hit;
    logic [7:0] code;
    logic [PIX_W-1:0] mval;
    logic [PIX_W-1:0] sval;
    logic [1:0] rep_max;

    if (PIX_W != 10) begin : g_bad_width
        $error("spp_packetizer: packet layout needs PIX_W of 10");
    end

    // ==========================================================
    // helpers
    // put a reserved word into the field that is sent, except in stereo packets with w10 set
    function automatic logic [PIX_W-1:0] place(input logic [7:0] c,
                                               input logic w10);
        if (w10) begin
            return {2'h0, c};
        end else begin
            return {c, 2'h0};
        end
    endfunction

    // substitute values that would look like a reserved word, except in stereo packets with w10 set
    function automatic logic [PIX_W-1:0] clamp(input logic [PIX_W-1:0] v,
                                               input logic w10);
        if (w10) begin
            return (v < {2'h0, spp_pkg::SUBST}) ? {2'h0, spp_pkg::SUBST} : v;
        end else begin
            return (v[9:2] < spp_pkg::SUBST) ? {spp_pkg::SUBST, 2'h0} : v;
        end
    endfunction

    // ==========================================================
    // serialiser
    spp_shift #(
        .MAX_LEN(spp_pkg::SHIFT_W)
    ) u_shift (
        .clk(clk),
        .nrst(nrst),
        .word(word),
        .len(len),
        .ser_out(ser_out),
        .last(last),
        .almost(almost)
    );

    assign pix_take = cur.take;
    assign pkt_start = cur.start;

    // reserved word choice for the middle sample
    always_comb begin
        code_hit = 1'b1;
        code = spp_pkg::WORD_IMG_FALL;
        if (!cur.p_img && cur.q_img) begin
            code = spp_pkg::WORD_IMG_FALL;
        end else if (!cur.p_row && cur.q_row) begin
            code = spp_pkg::WORD_ROW_FALL;
        end else if (!cur.p_img && cur.n_img) begin
            code = spp_pkg::WORD_IMG_RISE;
        end else if (!cur.p_row && cur.n_row) begin
            code = spp_pkg::WORD_ROW_RISE;
        end else begin
            code_hit = 1'b0;
        end
    end

    // field values and packet word
    always_comb begin
        mval = code_hit ? place(code, cur.w10)
                        : clamp(cur.p_pix, cur.w10);
        sval = code_hit ? place(code, cur.w10)
                        : clamp(cur.p_spix, cur.w10);
        if (cur.st) begin
            word = {spp_pkg::STOP_BIT, sval[9:2], mval[9:2],
                    spp_pkg::START_BIT};
            len = spp_pkg::LEN_STEREO;
        end else if (cur.w10) begin
            word = {6'h00, spp_pkg::STOP_BIT, mval,
                    spp_pkg::START_BIT};
            len = spp_pkg::LEN_SOLO;
        end else begin
            word = {6'h00, spp_pkg::STOP_BIT, cur.p_img, cur.p_row,
                    mval[9:2], spp_pkg::START_BIT};
            len = spp_pkg::LEN_SOLO;
        end
    end

    // repeat count, pipeline advance and mode capture
    always_comb begin
        next_cur = cur;
        case (cur.bin)
            spp_pkg::BIN_X2: rep_max = spp_pkg::REP_X2;
            spp_pkg::BIN_X4: rep_max = spp_pkg::REP_X4;
            default: rep_max = spp_pkg::REP_X1;
        endcase
        next_cur.take = almost && (cur.rep >= rep_max);
        next_cur.start = last;
        if (last) begin
            next_cur.pkt18 = cur.st;
            if (cur.take) begin
                next_cur.rep = 2'h0;
                next_cur.q_row = cur.p_row;
                next_cur.q_img = cur.p_img;
                next_cur.p_pix = cur.n_pix;
                next_cur.p_spix = cur.n_spix;
                next_cur.p_row = cur.n_row;
                next_cur.p_img = cur.n_img;
                next_cur.n_pix = pix;
                next_cur.n_spix = slave_pix;
                next_cur.n_row = row_active;
                next_cur.n_img = image_active;
                next_cur.st = stereo;
                next_cur.w10 = use_10bit;
                next_cur.bin = col_bin;
            end else begin
                next_cur.rep = cur.rep + 2'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_start_bit_high: assert property (
        pkt_start |-> ser_out == spp_pkg::START_BIT)
        else $error("packet does not open with a start bit");

    chk_solo_stop_next: assert property (
        pkt_start && !cur.pkt18 |-> ##11 (ser_out == spp_pkg::STOP_BIT)
            ##1 pkt_start)
        else $error("solo packet stop or spacing wrong");

    chk_stereo_stop_next: assert property (
        pkt_start && cur.pkt18 |-> ##17 (ser_out == spp_pkg::STOP_BIT)
            ##1 pkt_start)
        else $error("stereo packet stop or spacing wrong");

    chk_byte_mode_flags: assert property (
        last && !cur.st && !cur.w10 |->
            ##10 (ser_out == $past(cur.p_row, 10))
            ##1 (ser_out == $past(cur.p_img, 11)))
        else $error("row or image flag misplaced in 8-bit packet");

    chk_wide_mode_lsb: assert property (
        last && !cur.st && cur.w10 && !code_hit &&
            cur.p_pix >= 10'h004 |-> ##2 (ser_out == $past(cur.p_pix[0], 2)))
        else $error("10-bit packet does not send pixel lsb first");

    chk_code_zero_sent: assert property (
        last && code_hit && code == spp_pkg::WORD_IMG_RISE |->
            ##2 (ser_out == 1'b0) [*8])
        else $error("image start word not sent as zero");

    chk_clamp_subst: assert property (
        last && !code_hit && cur.w10 && !cur.st |->
            word[10:1] >= 10'h004)
        else $error("reserved pixel value leaked into stream");

    chk_bin2_repeat: assert property (
        pix_take ##1 (cur.bin == spp_pkg::BIN_X2 && !cur.st) |->
            (!pix_take) [*8] ##16 pix_take)
        else $error("2x binning does not repeat pixel twice");

    chk_bin4_repeat: assert property (
        pix_take ##1 (cur.bin == spp_pkg::BIN_X4 && !cur.st) |->
            ##47 pix_take)
        else $error("4x binning does not repeat pixel four times");

    cov_stereo_pkt: cover property (pkt_start && cur.pkt18);
    cov_bin4_take: cover property (pix_take && cur.bin == spp_pkg::BIN_X4);
    cov_row_rise: cover property (last && code_hit &&
        code == spp_pkg::WORD_ROW_RISE);
    cov_clamped: cover property (last && !code_hit && cur.p_img &&
        cur.p_pix < 10'h004);
endmodule // spp_packetizer

/* File: src/spp_pkg.sv */
package spp_pkg;
    // ==========================================================
    // pixel and packet geometry
    localparam int PIX_W = 10;
    localparam int SHIFT_W = 18;
    localparam logic [4:0] LEN_SOLO = 5'h0c;
    localparam logic [4:0] LEN_STEREO = 5'h12;
    localparam logic START_BIT = 1'b1;
    localparam logic STOP_BIT = 1'b0;
    localparam logic IDLE_BIT = 1'b0;

    // ==========================================================
    // reserved words and substitution value, in sent-field units
    localparam logic [7:0] WORD_IMG_RISE = 8'h00;
    localparam logic [7:0] WORD_ROW_RISE = 8'h01;
    localparam logic [7:0] WORD_ROW_FALL = 8'h02;
    localparam logic [7:0] WORD_IMG_FALL = 8'h03;
    localparam logic [7:0] SUBST = 8'h04;

    // ==========================================================
    // column binning select codes and repeat limits
    localparam logic [1:0] BIN_X2 = 2'h1;
    localparam logic [1:0] BIN_X4 = 2'h2;
    localparam logic [1:0] REP_X1 = 2'h0;
    localparam logic [1:0] REP_X2 = 2'h1;
    localparam logic [1:0] REP_X4 = 2'h3;
endpackage

/* File: src/spp_shift.sv */
`timescale 1ns/100ps
module spp_shift #(
    parameter int MAX_LEN = spp_pkg::SHIFT_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [MAX_LEN-1:0] word,
    input wire logic [4:0] len,
    output logic ser_out,
    output logic last,
    output logic almost
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [MAX_LEN-1:0] sh;
        logic [4:0] cnt;
        logic [4:0] len;
    } spp_shift_s;

    spp_shift_s cur;
    spp_shift_s next_cur;

    if (MAX_LEN < 18 || MAX_LEN > 31) begin : g_bad_len
        $error("spp_shift: MAX_LEN must be 18 to 31");
    end

    // end-of-packet flags for the framer
    assign last = (cur.cnt == cur.len - 5'h01);
    assign almost = (cur.cnt == cur.len - 5'h02);
    assign ser_out = cur.sh[0];

    // load on the last bit, otherwise shift out lsb first
    always_comb begin
        next_cur = cur;
        if (last) begin
            next_cur.sh = word;
            next_cur.cnt = 5'h00;
            next_cur.len = len;
        end else begin
            next_cur.sh = {1'b0, cur.sh[MAX_LEN-1:1]};
            next_cur.cnt = cur.cnt + 5'h01;
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur.sh <= '0;
            cur.cnt <= 5'h00;
            cur.len <= spp_pkg::LEN_SOLO;
        end else begin
            cur <= next_cur;
        end
    end
endmodule // spp_shift

/* File: testbench/spp_rx_model.sv */
`timescale 1ns/100ps
module spp_rx_model (
    input wire logic clk,
    input wire logic ser_in,
    input wire logic mark,
    input wire logic [4:0] len,
    input wire logic [1:0] reps,
    output logic [17:0] pkt,
    output logic got,
    output logic keep,
    output logic row_rx,
    output logic img_rx
);
    logic [17:0] sh = '0;
    logic [4:0] n = 5'h1f;
    logic [1:0] k = 2'h0;
    initial {pkt, got, keep, row_rx, img_rx} = '0;
    // ==========================================================
    // gather bits from position 0, publish on the stop bit
    always @(posedge clk) begin
        got = 1'h0;
        if (mark)
            n = 5'h00;
        if (n < len) begin
            sh[n] = ser_in;
            n = n + 5'h01;
            if (n == len) begin
                pkt = sh;
                got = 1'h1;
                k = (k == reps) ? 2'h0 : k + 2'h1;
                keep = (k == 2'h0);
                // flags rebuilt from reserved bytes
                case (sh[8:1])
                    8'h00: img_rx = 1'h1;
                    8'h01: row_rx = 1'h1;
                    8'h02: row_rx = 1'h0;
                    8'h03: img_rx = 1'h0;
                    default: ;
                endcase
            end
        end
    end
endmodule // spp_rx_model

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic clk, nrst, use_10bit, stereo, row_active, image_active;
    logic pix_take, pkt_start, ser_out, got, keep, row_rx, img_rx;
    logic [1:0] col_bin, reps;
    logic [9:0] pix, slave_pix;
    logic [17:0] pkt;
    logic [9:0] rx_q[$];
    int fail_count, samples_checked;
    assign reps = col_bin == spp_pkg::BIN_X4 ? spp_pkg::REP_X4 :
        col_bin == spp_pkg::BIN_X2 ? spp_pkg::REP_X2 : spp_pkg::REP_X1;
    spp_packetizer dut_u (.clk(clk), .nrst(nrst), .use_10bit(use_10bit),
        .stereo(stereo), .col_bin(col_bin), .pix(pix),
        .slave_pix(slave_pix), .row_active(row_active),
        .image_active(image_active), .pix_take(pix_take),
        .pkt_start(pkt_start), .ser_out(ser_out));
    spp_rx_model rx_u (.clk(clk), .ser_in(ser_out), .mark(pkt_start),
        .len(stereo ? spp_pkg::LEN_STEREO : spp_pkg::LEN_SOLO),
        .reps(reps), .pkt(pkt), .got(got), .keep(keep),
        .row_rx(row_rx), .img_rx(img_rx));
    // ==========================================================
    // clock, watchdog, packet log
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        #2000000;
        fail_count++;
        end_of_test;
    end
    always @(negedge clk) if (got === 1'h1) begin
        rx_q.push_back(pkt[10:1]);
    end
    // ==========================================================
    // helpers
    task end_of_test;
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [17:0] g, input logic [17:0] e);
        samples_checked++;
        if (g !== e) begin
            $display("BAD %0t got %h want %h", $time, g, e);
            fail_count++;
        end
    endtask
    task wait_take;
        int n;
        n = 0;
        @(negedge clk);
        while (pix_take !== 1'h1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            $display("BAD %0t no pixel take seen", $time);
            fail_count++;
        end
    endtask
    task put(input logic w, s, input logic [1:0] b, input logic r, i,
            input logic [9:0] p, q);
        wait_take;
        {use_10bit, stereo, col_bin} = {w, s, b};
        {row_active, image_active} = {r, i};
        {pix, slave_pix} = {p, q};
    endtask
    task put8(input logic r, i);
        put(1'h0, 1'h0, 2'h0, r, i, 10'h3fc, 10'h3fc);
    endtask
    // ==========================================================
    // scenarios
    task steady(input logic w, s, input logic [1:0] b, input logic [9:0] p, q);
        logic [7:0] mb, sb;
        logic [9:0] f;
        logic [17:0] e;
        int c, n, kc;
        mb = p[9:2] < 8'h04 ? spp_pkg::SUBST : p[9:2];
        sb = q[9:2] < 8'h04 ? spp_pkg::SUBST : q[9:2];
        f = p < 10'h004 ? 10'h004 : p;
        e = s ? {1'h0, sb, mb, 1'h1} : w ? {7'h00, f, 1'h1} :
            {6'h00, 3'h3, mb, 1'h1};
        repeat (5) put(w, s, b, 1'h1, 1'h1, p, q);
        wait_take;
        c = 0;
        n = 0;
        kc = 0;
        do begin
            @(negedge clk);
            c += int'(got === 1'h1);
            kc += int'(got === 1'h1 && keep === 1'h1);
            n++;
        end while (pix_take !== 1'h1 && n < 80);
        chk(18'(c), b == 2'h1 ? 18'h2 : b == 2'h2 ? 18'h4 : 18'h1);
        chk(18'(n), 18'(c * (s ? 18 : 12)));
        chk(18'(kc), 18'h0_0001);
        chk(s ? pkt : {6'h00, pkt[11:0]}, e);
    endtask
    task t_reserved;
        int fi = -1, fr = -1, lr = -1, li = -1;
        repeat (4) put8(1'h0, 1'h0);
        rx_q.delete();
        repeat (3) put8(1'h0, 1'h0);
        repeat (3) put8(1'h0, 1'h1);
        repeat (3) put8(1'h1, 1'h1);
        repeat (3) put8(1'h0, 1'h1);
        repeat (5) put8(1'h0, 1'h0);
        foreach (rx_q[k]) begin
            if (rx_q[k][9] && fi < 0) fi = k;
            if (rx_q[k][8] && fr < 0) fr = k;
            if (rx_q[k][8]) lr = k;
            if (rx_q[k][9]) li = k;
        end
        chk(18'(rx_q[fi-1][7:0]), 18'(spp_pkg::WORD_IMG_RISE));
        chk(18'(rx_q[fr-1][7:0]), 18'(spp_pkg::WORD_ROW_RISE));
        chk(18'(rx_q[lr+1][7:0]), 18'(spp_pkg::WORD_ROW_FALL));
        chk(18'(rx_q[li+1][7:0]), 18'(spp_pkg::WORD_IMG_FALL));
        chk(18'(rx_q[fr][7:0]), 18'h0_00ff);
        chk(18'({row_rx, img_rx}), 18'h0);
    endtask
    task t_subst10;
        int c4 = 0, low = 0;
        logic [9:0] seq[8] = '{10'h3ff, 10'h000, 10'h3ff, 10'h003,
            10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff};
        repeat (4) put(1'h1, 1'h0, 2'h0, 1'h1, 1'h1, 10'h3ff, 10'h000);
        rx_q.delete();
        foreach (seq[k]) put(1'h1, 1'h0, 2'h0, 1'h1, 1'h1, seq[k], 10'h000);
        foreach (rx_q[k]) begin
            c4 += int'(rx_q[k] === 10'h004);
            low += int'(rx_q[k] < 10'h004 || $isunknown(rx_q[k]));
        end
        chk(18'(c4), 18'h2);
        chk(18'(low), 18'h0);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {nrst, use_10bit, stereo, col_bin, row_active, image_active} = '0;
        {pix, slave_pix} = '0;
        fail_count = 0;
        samples_checked = 0;
        repeat (6) @(negedge clk);
        nrst = 1'h1;
        steady(1'h0, 1'h0, 2'h0, 10'h2a5, 10'h000);
        steady(1'h1, 1'h0, 2'h3, 10'h2a5, 10'h000);
        steady(1'h0, 1'h1, 2'h0, 10'h2a5, 10'h1c6);
        steady(1'h0, 1'h0, 2'h0, 10'h00f, 10'h000);
        steady(1'h1, 1'h0, 2'h1, 10'h2a5, 10'h000);
        steady(1'h0, 1'h0, 2'h2, 10'h2a5, 10'h000);
        steady(1'h0, 1'h1, 2'h2, 10'h1c6, 10'h00d);
        t_reserved;
        t_subst10;
        end_of_test;
    end
endmodule // tb_top
